// File: rtl/asr_defs.vh
// Purpose: constants for the angle sensor readout register bank
// Assumes: 16-bit register words, byte offsets as printed
// Notes: included by asr_regs.v
//
// Function
// R1: the field word carries tag 1110 in bits 15:12 and the turns word carries tag 110 in 15:13.
// R2: the field word holds the 12-bit field magnitude, refreshed every 128 us.
// R3: the turns field is a 12-bit two's complement count relative to power-up.
// R4: the count step is 180 or 45 degrees by configuration, ranges -512..511 or -2048..2047.
// R5: the counter tracks up to 256 full rotations in either direction in both modes; the code tracks only 255 up (511 or 2047 steps).
// R6: bit 12 of the turns, hysteresis and crossing-path words makes the word odd parity.
// R7: bit 14 of both angle words is the OR of unmasked error and warning bits.
// R8: bit 13 of both angle words is the real-time masked OR of analog and digital supply low.
// R9: the hysteresis word holds the loop angle after hysteresis in bits 11:0.
// R10: the fine angle word reads 0 in bit 15 and the 15-bit compensated angle in 14:0.
// R11: the crossing-path word holds the uncompensated 12-bit angle used for turn counting.
// R12: the host unlocks by writing codes 00, 27, 81, 1F, 77 in succession to bits 15:8.
// R13: writes to nonvolatile and shadow registers and special commands pass only when unlocked.
// R14: key bit 0 reads 1 when unlocked, bits 7:1 read 0.
// R15: an overflow flag latches when turns pass +255 or -256 rotations, cleared by turns reset.
// R16: a wrong code at any unlock step restarts the sequence.
// R17: unlock code bits read zero and writes to read-only words are ignored.
`ifndef ASR_DEFS_VH
`define ASR_DEFS_VH
`define ASR_OFS_FIELD 8'h2A
`define ASR_OFS_TURNS 8'h2C
`define ASR_OFS_HYST_ANGLE 8'h30
`define ASR_OFS_FINE_ANGLE 8'h32
`define ASR_OFS_CROSS_ANGLE 8'h34
`define ASR_OFS_KEY 8'h3C
`define ASR_TAG_FIELD 4'hE
`define ASR_TAG_TURNS 3'h6
`define ASR_KEY_CODE0 8'h00
`define ASR_KEY_CODE1 8'h27
`define ASR_KEY_CODE2 8'h81
`define ASR_KEY_CODE3 8'h1F
`define ASR_KEY_CODE4 8'h77
`define ASR_FIELD_PERIOD_US 128
`define ASR_CLK_MHZ 10
`define ASR_FIELD_CYCLES (`ASR_FIELD_PERIOD_US * `ASR_CLK_MHZ)
`define ASR_TURNS_MAX180 12'h1FF
`define ASR_TURNS_MIN180 12'hE00
`define ASR_TURNS_MAX45 12'h7FF
`define ASR_TURNS_MIN45 12'h800
`endif

// File: rtl/asr_regs.v
// Purpose: result word bank and unlock key of a magnetic angle sensor
// Assumes: register port is a 16-bit word access with byte offset, one clock
// Notes: sensor inputs come from logic on mclk; writes act on the pulse only
`timescale 1ns/1ps
`default_nettype none
`include "asr_defs.vh"

module asr_regs #(
    parameter FIELD_CYCLES = `ASR_FIELD_CYCLES
) (
    input wire mclk,
    input wire rst_n,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [15:0] reg_wdata,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire [11:0] field_gauss,
    input wire [11:0] hysteresis_angle,
    input wire [14:0] fine_angle,
    input wire [11:0] crossing_path_angle,
    input wire step45_sel,
    input wire turn_up,
    input wire turn_dn,
    input wire turns_reset,
    input wire error_summary_in,
    input wire analog_supply_low,
    input wire digital_supply_low,
    input wire mask_analog_low,
    input wire mask_digital_low,
    input wire nv_wr_req,
    input wire special_cmd_req,
    output reg nv_wr_grant,
    output reg special_cmd_grant,
    output reg unlocked_flag,
    output reg rotation_overflow_flag
);

    // ----------------------------------------------------------------
    // field magnitude sampling
    // ----------------------------------------------------------------
    reg [11:0] field_q;
    reg [15:0] fcnt_q;
    always @(posedge mclk) begin
        if (!rst_n) begin
            field_q <= 12'h000;
            fcnt_q <= 16'h0000;
        end else if (fcnt_q == FIELD_CYCLES - 1) begin
            fcnt_q <= 16'h0000;
            field_q <= field_gauss; // R2
        end else begin
            fcnt_q <= fcnt_q + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // turns counter
    // ----------------------------------------------------------------
    reg [11:0] turns_q;
    wire [11:0] tmax = step45_sel ? `ASR_TURNS_MAX45 : `ASR_TURNS_MAX180; // R4
    wire [11:0] tmin = step45_sel ? `ASR_TURNS_MIN45 : `ASR_TURNS_MIN180; // R4
    wire up_ev = turn_up & ~turn_dn;
    wire dn_ev = turn_dn & ~turn_up;
    wire at_max = (turns_q == tmax);
    wire at_min = (turns_q == tmin);
    always @(posedge mclk) begin
        if (!rst_n) begin
            turns_q <= 12'h000; // R3
            rotation_overflow_flag <= 1'b0;
        end else if (turns_reset) begin
            turns_q <= 12'h000;
            rotation_overflow_flag <= 1'b0; // R15
        end else begin
            if (up_ev) begin
                if (at_max)
                    rotation_overflow_flag <= 1'b1; // R15
                else
                    turns_q <= turns_q + 12'h001; // R3 R5
            end else if (dn_ev) begin
                if (at_min)
                    rotation_overflow_flag <= 1'b1; // R15
                else
                    turns_q <= turns_q - 12'h001; // R3 R5
            end
        end
    end

    // ----------------------------------------------------------------
    // status flags for angle words
    // ----------------------------------------------------------------
    wire supply_low_flag = (analog_supply_low & ~mask_analog_low)
        | (digital_supply_low & ~mask_digital_low); // R8
    wire error_summary_flag = error_summary_in; // R7

    // ----------------------------------------------------------------
    // unlock sequence
    // ----------------------------------------------------------------
    reg [2:0] step_q;
    reg [7:0] expect_code;
    wire [7:0] unlock_code = reg_wdata[15:8];
    wire key_wr = reg_wr && (reg_addr == `ASR_OFS_KEY);
    always @* begin
        case (step_q)
            3'h0: expect_code = `ASR_KEY_CODE0;
            3'h1: expect_code = `ASR_KEY_CODE1;
            3'h2: expect_code = `ASR_KEY_CODE2;
            3'h3: expect_code = `ASR_KEY_CODE3;
            3'h4: expect_code = `ASR_KEY_CODE4;
            default: expect_code = `ASR_KEY_CODE0;
        endcase
    end
    always @(posedge mclk) begin
        if (!rst_n) begin
            step_q <= 3'h0;
            unlocked_flag <= 1'b0;
        end else if (key_wr) begin
            if (unlock_code == expect_code) begin
                if (step_q == 3'h4) begin
                    step_q <= 3'h0;
                    unlocked_flag <= 1'b1; // R14
                end else begin
                    step_q <= step_q + 3'h1;
                end
            end else if (unlock_code == `ASR_KEY_CODE0) begin
                step_q <= 3'h1; // R16
                unlocked_flag <= 1'b0;
            end else begin
                step_q <= 3'h0; // R16
                unlocked_flag <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // unlock gating of protected actions
    // ----------------------------------------------------------------
    always @(posedge mclk) begin
        if (!rst_n) begin
            nv_wr_grant <= 1'b0;
            special_cmd_grant <= 1'b0;
        end else begin
            nv_wr_grant <= nv_wr_req & unlocked_flag; // R13
            special_cmd_grant <= special_cmd_req & unlocked_flag; // R13
        end
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    reg [15:0] rd_d;
    reg [14:0] body;
    always @* begin
        rd_d = 16'h0000;
        body = 15'h0000;
        case (reg_addr)
            `ASR_OFS_FIELD: rd_d = {`ASR_TAG_FIELD, field_q}; // R1 R2
            `ASR_OFS_TURNS: begin
                body = {`ASR_TAG_TURNS, 12'h000} | {3'h0, turns_q};
                rd_d = {body[14:12], ~^{body[14:12], turns_q}, turns_q}; // R1 R6
            end
            `ASR_OFS_HYST_ANGLE: begin
                body = {1'b0, error_summary_flag, supply_low_flag, hysteresis_angle};
                rd_d = {1'b0, error_summary_flag, supply_low_flag,
                    ~^body, hysteresis_angle}; // R6 R7 R8 R9
            end
            `ASR_OFS_FINE_ANGLE: rd_d = {1'b0, fine_angle}; // R10
            `ASR_OFS_CROSS_ANGLE: begin
                body = {1'b0, error_summary_flag, supply_low_flag, crossing_path_angle};
                rd_d = {1'b0, error_summary_flag, supply_low_flag,
                    ~^body, crossing_path_angle}; // R6 R7 R8 R11
            end
            `ASR_OFS_KEY: rd_d = {15'h0000, unlocked_flag}; // R14 R17
            default: rd_d = 16'h0000;
        endcase
    end

    // writes to result words have no path into any storage
    always @(posedge mclk) begin
        if (!rst_n)
            reg_rdata <= 16'h0000;
        else if (reg_rd)
            reg_rdata <= rd_d; // R17
    end

endmodule // asr_regs
`default_nettype wire

// File: test/asr_regs_assertions.sv
// Purpose: port checks of the angle sensor result bank
// Assumes: read data is registered at the edge that takes the strobe
// Notes: bound into asr_regs
`timescale 1ns/1ps
`default_nettype none
module asr_regs_chk (
    input wire mclk,
    input wire rst_n,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire [11:0] crossing_path_angle,
    input wire error_summary_in,
    input wire turns_reset,
    input wire nv_wr_req,
    input wire nv_wr_grant,
    input wire special_cmd_grant,
    input wire unlocked_flag,
    input wire rotation_overflow_flag
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    a_field_tag: assert property (reg_rd && reg_addr == 8'h2A |=> reg_rdata[15:12] == 4'hE)
        else $error("field tag wrong");
    a_turns_word: assert property (reg_rd && reg_addr == 8'h2C |=>
        reg_rdata[15:13] == 3'h6 && ^reg_rdata) else $error("turns word wrong");
    a_cross_word: assert property (reg_rd && reg_addr == 8'h34 |=> ^reg_rdata &&
        reg_rdata[14] == $past(error_summary_in) && reg_rdata[11:0] == $past(crossing_path_angle))
        else $error("crossing word wrong");
    a_key_low: assert property (reg_rd && reg_addr == 8'h3C |=> reg_rdata[15:1] == 15'h0000)
        else $error("key upper bits set");
    a_nv_grant: assert property (nv_wr_req |=> nv_wr_grant == $past(unlocked_flag))
        else $error("nv grant wrong");
    a_special_lock: assert property (!unlocked_flag |=> !special_cmd_grant)
        else $error("command granted while locked");
    a_ovf_latch: assert property (rotation_overflow_flag && !turns_reset |=> rotation_overflow_flag)
        else $error("overflow dropped");
    a_relock_key: assert property (unlocked_flag && reg_wr && reg_addr == 8'h3C |=> !unlocked_flag)
        else $error("still unlocked");
endmodule // asr_regs_chk
bind asr_regs asr_regs_chk i_chk (.*);
`default_nettype wire

// File: test/asr_host_model.sv
// Purpose: host side of the register port
// Assumes: strobes rise 1 ns after an edge, drop after the taking edge
// Notes: idle address and data lines show the inverse of the last value, both strobes low
`timescale 1ns/1ps
`default_nettype none
module asr_host_model (
    input wire logic mclk,
    input wire logic [15:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [15:0] reg_wdata,
    output logic reg_rd
);
    localparam logic [39:0] KEY_SEQ = 40'h0027811F77;
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 26'h0000000;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                        output logic [15:0] q);
        @(posedge mclk);
        #1;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
        @(posedge mclk);
        #1;
        q = reg_rdata;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = {~a, ~d, 2'h0};
    endtask
    task automatic unlock;
        logic [15:0] q;
        for (int i = 4; i >= 0; i--) xfer(1'b1, 8'h3C, {KEY_SEQ[8*i +: 8], 8'h00}, q);
    endtask
endmodule // asr_host_model
`default_nettype wire

// File: test/tb_top.sv
// Purpose: self-checking bench for the angle sensor result bank
// Assumes: host model drives the register port, bench the sensor side
// Notes: field refresh shortened to 8 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk = 1'b0, rst_n = 1'b0, reg_wr, reg_rd, exp_unl = 1'b0;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, q;
    logic [11:0] field_gauss = 12'h000, hysteresis_angle = 12'h000, turns_q = 12'h000;
    logic [11:0] crossing_path_angle = 12'h000;
    logic [14:0] fine_angle = 15'h0000;
    logic step45_sel = 1'b0, turn_up = 1'b0, turn_dn = 1'b0, turns_reset = 1'b0;
    logic error_summary_in = 1'b0, analog_supply_low = 1'b0, digital_supply_low = 1'b0;
    logic mask_analog_low = 1'b0, mask_digital_low = 1'b0, nv_wr_req = 1'b0, special_cmd_req = 1'b0;
    logic nv_wr_grant, special_cmd_grant, unlocked_flag, rotation_overflow_flag;
    logic [63:0] r;
    logic [7:0] adrs [7] = '{8'h2A, 8'h2C, 8'h30, 8'h32, 8'h34, 8'h3C, 8'h41};
    int error_cnt = 0, total_checks = 0, lim;
    always #50 mclk = ~mclk;
    asr_regs #(.FIELD_CYCLES(8)) i_dut (.*);
    asr_host_model i_host (.*);
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    function automatic logic [15:0] exp_word(input logic [7:0] a);
        logic [15:0] w;
        logic supply_low;
        supply_low = (analog_supply_low & !mask_analog_low)
            | (digital_supply_low & !mask_digital_low);
        case (a)
            8'h2A: w = {4'hE, field_gauss};
            8'h2C: w = {3'h6, 1'h0, turns_q};
            8'h30: w = {1'h0, error_summary_in, supply_low, 1'h0, hysteresis_angle};
            8'h32: w = {1'h0, fine_angle};
            8'h34: w = {1'h0, error_summary_in, supply_low, 1'h0, crossing_path_angle};
            8'h3C: w = {15'h0000, exp_unl};
            default: w = 16'h0000;
        endcase
        if (a == 8'h2C || a == 8'h30 || a == 8'h34) w[12] = ~^w;
        return w;
    endfunction
    task automatic chk(input logic [7:0] a);
        i_host.xfer(1'b0, a, 16'h0000, q);
        cmp($sformatf("word %h", a), exp_word(a), q);
    endtask
    task automatic pulse(input logic [2:0] v, input int n);
        repeat (n) begin
            @(posedge mclk);
            #1;
            {turn_up, turn_dn, turns_reset} = v;
            @(posedge mclk);
            #1;
            {turn_up, turn_dn, turns_reset} = 3'h0;
        end
    endtask
    initial begin
        #3000000;
        error_cnt++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(32'h23E32DE1));
        repeat (16) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        for (int u = 0; u < 2; u++) begin
            if (u) i_host.unlock;
            exp_unl = u[0];
            repeat (12) begin
                r = {$urandom, $urandom};
                {field_gauss, hysteresis_angle, fine_angle, crossing_path_angle} = r[50:0];
                {error_summary_in, analog_supply_low, digital_supply_low, mask_analog_low,
                 mask_digital_low, nv_wr_req, special_cmd_req} = r[57:51];
                repeat (10) @(posedge mclk);
                foreach (adrs[i]) chk(adrs[i]);
                cmp("nv grant", {15'h0000, nv_wr_req & exp_unl}, {15'h0000, nv_wr_grant});
                cmp("cmd grant", {15'h0000, special_cmd_req & exp_unl}, {15'h0000, special_cmd_grant});
            end
            $display("random pass %0d done", u);
        end
        i_host.xfer(1'b1, 8'h30, 16'hFFFF, q);
        chk(8'h30);
        i_host.xfer(1'b1, 8'h3C, 16'h2700, q);
        exp_unl = 1'b0;
        chk(8'h3C);
        i_host.xfer(1'b1, 8'h3C, 16'h0000, q);
        i_host.xfer(1'b1, 8'h3C, 16'h5500, q);
        i_host.unlock;
        exp_unl = 1'b1;
        chk(8'h3C);
        $display("key tests done");
        for (int m = 0; m < 2; m++) begin
            step45_sel = m[0];
            lim = m ? 2047 : 511;
            pulse(3'h1, 1);
            pulse(3'h4, lim + 1);
            turns_q = lim[11:0];
            chk(8'h2C);
            cmp("overflow", 16'h0001, {15'h0000, rotation_overflow_flag});
            pulse(3'h1, 1);
            cmp("overflow", 16'h0000, {15'h0000, rotation_overflow_flag});
            pulse(3'h2, lim + 2);
            turns_q = ~lim[11:0];
            chk(8'h2C);
            cmp("overflow", 16'h0001, {15'h0000, rotation_overflow_flag});
            $display("turns mode %0d done", m);
        end
        tally_and_finish;
    end
endmodule // tb_top
`default_nettype wire
